// ---- core/timer_wave_pkg.sv ----
// Shared constants and types of the timer waveform block
package timer_wave_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets on the plain register port
	localparam logic [2:0] ADDR_CTRL_A = 3'h0;
	localparam logic [2:0] ADDR_CTRL_B = 3'h1;
	localparam logic [2:0] ADDR_COUNT  = 3'h2;
	localparam logic [2:0] ADDR_CMP_A  = 3'h3;
	localparam logic [2:0] ADDR_CMP_B  = 3'h4;
	localparam logic [2:0] ADDR_FLAGS  = 3'h5;

	////////////////////////////////////////////////////////////////////////////
	// Field positions, write masks and reset values
	localparam int         CHAN_A_MODE_LSB = 6;
	localparam int         CHAN_B_MODE_LSB = 4;
	localparam int         WAVE_LOW_LSB    = 0;
	localparam int         WAVE_HIGH_POS   = 3;
	localparam int         CLK_SEL_LSB     = 0;
	localparam logic [7:0] CTRL_A_WMASK    = 8'hf3;
	localparam logic [7:0] CTRL_B_WMASK    = 8'h0f;
	localparam logic [7:0] CTRL_A_RESET    = 8'h00;
	localparam logic [7:0] CTRL_B_RESET    = 8'h00;
	localparam int         FLAG_OVF        = 0;
	localparam int         FLAG_MATCH_A    = 1;
	localparam int         FLAG_MATCH_B    = 2;

	////////////////////////////////////////////////////////////////////////////
	// Counter limits
	localparam logic [7:0] COUNT_MAX    = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Waveform modes and output modes
	localparam logic [2:0] WAVE_NORMAL   = 3'h0;
	localparam logic [2:0] WAVE_PC_MAX   = 3'h1;
	localparam logic [2:0] WAVE_CTC      = 3'h2;
	localparam logic [2:0] WAVE_FAST_MAX = 3'h3;
	localparam logic [2:0] WAVE_RESV_4   = 3'h4;
	localparam logic [2:0] WAVE_PC_CMP   = 3'h5;
	localparam logic [2:0] WAVE_RESV_6   = 3'h6;
	localparam logic [2:0] WAVE_FAST_CMP = 3'h7;
	localparam logic [1:0] OUT_OFF       = 2'h0;
	localparam logic [1:0] OUT_TOGGLE    = 2'h1;
	localparam logic [1:0] OUT_CLEAR     = 2'h2;
	localparam logic [1:0] OUT_SET       = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// Prescaler division masks (divide by 8, 32, 64, 128, 256, 1024)
	localparam logic [9:0] PRESC_MASK_8    = 10'h007;
	localparam logic [9:0] PRESC_MASK_32   = 10'h01f;
	localparam logic [9:0] PRESC_MASK_64   = 10'h03f;
	localparam logic [9:0] PRESC_MASK_128  = 10'h07f;
	localparam logic [9:0] PRESC_MASK_256  = 10'h0ff;
	localparam logic [9:0] PRESC_MASK_1024 = 10'h3ff;

	// Operating class of the waveform generator
	typedef enum logic [3:0]
	{
		CLS_NONPWM = 4'b0001,
		CLS_FAST   = 4'b0010,
		CLS_PHASE  = 4'b0100,
		CLS_RESV   = 4'b1000
	} wave_class_t;

endpackage

// ---- core/timer_prescaler.sv ----
// Timer clock prescaler producing one-cycle count ticks
module timer_prescaler
	import timer_wave_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	input  wire logic       i_clk_en,
	input  wire logic [2:0] i_clk_sel,
	output logic            o_tick
);

	typedef struct packed
	{
		logic [9:0] div;
		logic       tick;
	} presc_state_t;

	presc_state_t st_r;
	presc_state_t st_nxt;
	logic [9:0]   mask;

	////////////////////////////////////////////////////////////////////////////
	// Divider select and tick generation
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.div = 10'(st_r.div + 10'h001);
		unique case (i_clk_sel)
			3'h2: mask = PRESC_MASK_8;
			3'h3: mask = PRESC_MASK_32;
			3'h4: mask = PRESC_MASK_64;
			3'h5: mask = PRESC_MASK_128;
			3'h6: mask = PRESC_MASK_256;
			3'h7: mask = PRESC_MASK_1024;
			default: mask = 10'h000;
		endcase
		// Select 0 stops the timer
		st_nxt.tick = (i_clk_sel != 3'h0) && ((st_r.div & mask) == mask);
	end

	// State register, frozen by clock enable
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else if (i_clk_en)
			st_r <= st_nxt;
	end

	assign o_tick = st_r.tick;

endmodule

// ---- core/wave_channel.sv ----
// One compare-output waveform channel with pin override
module wave_channel
	import timer_wave_pkg::*;
#(
	parameter bit PWM_TOGGLE = 1'b1
)
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	input  wire logic       i_clk_en,
	input  wire logic [1:0] i_out_mode,
	input  wave_class_t     i_wave_class,
	input  wire logic       i_wave_mode_high_bit,
	input  wire logic       i_match,
	input  wire logic       i_wrap_top,
	input  wire logic       i_count_up,
	input  wire logic       i_cmp_is_top,
	output logic            o_wave_out,
	output logic            o_pin_override
);

	typedef struct packed
	{
		logic wave;
		logic ovr;
	} chan_state_t;

	chan_state_t st_r;
	chan_state_t st_nxt;
	logic        do_set;
	logic        do_clr;
	logic        do_tog;
	logic        tog_ok;
	logic        up_act;

	////////////////////////////////////////////////////////////////////////////
	// Output action per class and output mode
	always_comb
	begin
		st_nxt = st_r;
		do_set = 1'b0;
		do_clr = 1'b0;
		do_tog = 1'b0;
		tog_ok = PWM_TOGGLE && i_wave_mode_high_bit && (i_out_mode == OUT_TOGGLE);
		up_act = i_count_up && !i_cmp_is_top;
		unique case (i_wave_class)
			CLS_NONPWM:
			begin
				st_nxt.ovr = (i_out_mode != OUT_OFF);
				if (i_match)
				begin
					do_tog = (i_out_mode == OUT_TOGGLE);
					do_clr = (i_out_mode == OUT_CLEAR);
					do_set = (i_out_mode == OUT_SET);
				end
			end
			CLS_FAST:
			begin
				st_nxt.ovr = i_out_mode[1] | tog_ok;
				if (i_out_mode[1])
				begin
					// Match at TOP ignored, wrap action still taken
					if (i_match && !i_cmp_is_top)
					begin
						do_clr = (i_out_mode == OUT_CLEAR);
						do_set = (i_out_mode == OUT_SET);
					end
					else if (i_wrap_top)
					begin
						do_set = (i_out_mode == OUT_CLEAR);
						do_clr = (i_out_mode == OUT_SET);
					end
				end
				else
					do_tog = tog_ok && i_match;
			end
			CLS_PHASE:
			begin
				st_nxt.ovr = i_out_mode[1] | tog_ok;
				if (i_out_mode[1] && i_match)
				begin
					// Match at TOP takes the down-count action
					do_clr = ((i_out_mode == OUT_CLEAR) == up_act);
					do_set = !do_clr;
				end
				else
					do_tog = tog_ok && i_match;
			end
			CLS_RESV:
				st_nxt.ovr = 1'b0;
		endcase
		if (do_set)
			st_nxt.wave = 1'b1;
		else if (do_clr)
			st_nxt.wave = 1'b0;
		else if (do_tog)
			st_nxt.wave = !st_r.wave;
	end

	// State register, frozen by clock enable
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else if (i_clk_en)
			st_r <= st_nxt;
	end

	assign o_wave_out     = st_r.wave;
	assign o_pin_override = st_r.ovr;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	fast_clear_a: assert property (i_clk_en && i_wave_class == CLS_FAST
		&& i_out_mode == OUT_CLEAR && i_match && !i_cmp_is_top |=> !o_wave_out)
		else $error("fast pwm match did not clear output");
	resv_pin_a: assert property (i_clk_en && i_wave_class == CLS_RESV
		|=> !o_pin_override)
		else $error("reserved mode drives the pin");
	nonpwm_toggle_a: assert property (i_clk_en && i_wave_class == CLS_NONPWM
		&& i_out_mode == OUT_TOGGLE && i_match |=> o_wave_out != $past(o_wave_out))
		else $error("toggle on match missing");

endmodule

// ---- core/timer_wave_ctrl.sv ----
// 8-bit timer with two compare channels and waveform output control
//
// Notes on behaviour
// - Nonzero channel A output mode routes its waveform onto the pin, except in modes 4, 6 and in PWM mode 01 without the high mode bit.
// - Nonzero channel B output mode routes its waveform onto the pin, except in modes 4, 6 and in PWM mode 01.
// - Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM channel A: 10 clear on match set at TOP, 11 inverse.
// - PWM channel A mode 01 toggles on match only with high mode bit set.
// - Phase PWM channel A: 10 clears counting up, sets counting down; 11 inverse.
// - Fast PWM channel B: 10 clear match set TOP, 11 inverse, 01 reserved.
// - Phase PWM channel B: 10 clear up, set down, 11 inverse, 01 reserved.
// - Channel A compare equal to TOP in fast PWM 10 or 11: match ignored, TOP action still done.
// - Channel B compare equal to TOP in fast PWM 10 or 11: match ignored, TOP action still done.
// - Control A bits 3 and 2 always read zero.
// - Waveform mode is high bit from control B plus two low bits; 4, 6 reserved.
// - Modes 0 and 2: TOP 0xFF or compare A, immediate update, overflow at MAX.
// - Modes 1 and 5: phase correct, update at TOP, overflow at BOTTOM.
// - Modes 3 and 7: fast PWM, update at TOP, overflow at MAX or TOP.
// - MAX is 0xFF and BOTTOM is 0x00.
// - Fast PWM TOP action happens on the wrap from TOP to BOTTOM.
module timer_wave_ctrl
	import timer_wave_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	input  wire logic       i_clk_en,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	output logic            o_chan_a_wave_out,
	output logic            o_chan_a_pin_override,
	output logic            o_chan_b_wave_out,
	output logic            o_chan_b_pin_override,
	output logic            o_overflow_flag
);

	typedef struct packed
	{
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [7:0] count;
		logic [7:0] cmp_a_buf;
		logic [7:0] cmp_b_buf;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		logic       count_up;
		logic       match_block;
		logic [2:0] flags;
		logic [7:0] rdata;
	} timer_state_t;

	timer_state_t st_r;
	timer_state_t st_nxt;
	wave_class_t  wave_class;
	logic [2:0]   wave_mode;
	logic [7:0]   top;
	logic         tick;
	logic         at_top;
	logic         match_a;
	logic         match_b;
	logic         wrap_top;
	logic         ovf_set;
	logic         top_update;
	logic         wr_count;
	logic [2:0]   flag_set;
	logic [2:0]   flag_clr;
	logic [1:0]   chan_a_mode;
	logic [1:0]   chan_b_mode;

	////////////////////////////////////////////////////////////////////////////
	// Timer clock from the prescaler
	timer_prescaler u_presc
	(
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_clk_sel (st_r.ctrl_b[CLK_SEL_LSB +: 3]),
		.o_tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode
	always_comb
	begin
		wave_mode = {st_r.ctrl_b[WAVE_HIGH_POS], st_r.ctrl_a[WAVE_LOW_LSB +: 2]};
		chan_a_mode = st_r.ctrl_a[CHAN_A_MODE_LSB +: 2];
		chan_b_mode = st_r.ctrl_a[CHAN_B_MODE_LSB +: 2];
		unique case (wave_mode)
			WAVE_NORMAL,
			WAVE_CTC:      wave_class = CLS_NONPWM;
			WAVE_PC_MAX,
			WAVE_PC_CMP:   wave_class = CLS_PHASE;
			WAVE_FAST_MAX,
			WAVE_FAST_CMP: wave_class = CLS_FAST;
			WAVE_RESV_4,
			WAVE_RESV_6:   wave_class = CLS_RESV;
		endcase
		// TOP is compare A in modes 2, 5, 7, otherwise MAX
		if (wave_mode == WAVE_CTC || wave_mode == WAVE_PC_CMP || wave_mode == WAVE_FAST_CMP)
			top = st_r.cmp_a;
		else
			top = COUNT_MAX;
	end

	// Match and TOP events on a timer tick
	always_comb
	begin
		wr_count = i_wr && (i_addr == ADDR_COUNT);
		at_top   = (st_r.count == top);
		match_a  = tick && !st_r.match_block && (st_r.count == st_r.cmp_a);
		match_b  = tick && !st_r.match_block && (st_r.count == st_r.cmp_b);
		wrap_top = tick && at_top && (wave_class == CLS_FAST);
		top_update = tick && at_top
			&& (wave_class == CLS_FAST || wave_class == CLS_PHASE);
	end

	// Overflow flag source per mode
	always_comb
	begin
		ovf_set = 1'b0;
		if (tick)
		begin
			unique case (wave_mode)
				WAVE_NORMAL,
				WAVE_CTC,
				WAVE_FAST_MAX: ovf_set = (st_r.count == COUNT_MAX);
				WAVE_FAST_CMP: ovf_set = at_top;
				WAVE_PC_MAX,
				WAVE_PC_CMP:   ovf_set = !st_r.count_up && (st_r.count == COUNT_BOTTOM);
				WAVE_RESV_4,
				WAVE_RESV_6:   ovf_set = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state: counter, compare buffers, flags, registers
	always_comb
	begin
		st_nxt = st_r;
		flag_set = 3'h0;
		flag_clr = 3'h0;

		// Counting sequence
		if (tick)
		begin
			st_nxt.match_block = 1'b0;
			unique case (wave_class)
				CLS_PHASE:
				begin
					if (st_r.count_up)
					begin
						if (at_top)
						begin
							st_nxt.count_up = 1'b0;
							st_nxt.count = 8'(st_r.count - 8'h01);
						end
						else
							st_nxt.count = 8'(st_r.count + 8'h01);
					end
					else if (st_r.count == COUNT_BOTTOM)
					begin
						st_nxt.count_up = 1'b1;
						st_nxt.count = 8'(st_r.count + 8'h01);
					end
					else
						st_nxt.count = 8'(st_r.count - 8'h01);
				end
				CLS_NONPWM,
				CLS_FAST:
				begin
					st_nxt.count_up = 1'b1;
					if (at_top)
						st_nxt.count = COUNT_BOTTOM;
					else
						st_nxt.count = 8'(st_r.count + 8'h01);
				end
				CLS_RESV:
				begin
					st_nxt.count_up = 1'b1;
					st_nxt.count = 8'(st_r.count + 8'h01);
				end
			endcase
		end

		// Compare update: buffered at TOP in PWM, immediate otherwise
		if (top_update)
		begin
			st_nxt.cmp_a = st_r.cmp_a_buf;
			st_nxt.cmp_b = st_r.cmp_b_buf;
		end

		// Register writes
		if (i_wr)
		begin
			unique case (i_addr)
				ADDR_CTRL_A: st_nxt.ctrl_a = i_wdata & CTRL_A_WMASK;
				ADDR_CTRL_B: st_nxt.ctrl_b = i_wdata & CTRL_B_WMASK;
				ADDR_COUNT:
				begin
					st_nxt.count = i_wdata;
					st_nxt.match_block = 1'b1;
				end
				ADDR_CMP_A:  st_nxt.cmp_a_buf = i_wdata;
				ADDR_CMP_B:  st_nxt.cmp_b_buf = i_wdata;
				ADDR_FLAGS:  flag_clr = i_wdata[2:0];
				default:     flag_clr = 3'h0;
			endcase
		end

		// Immediate update in non-buffered modes
		if (wave_class == CLS_NONPWM || wave_class == CLS_RESV)
		begin
			st_nxt.cmp_a = st_nxt.cmp_a_buf;
			st_nxt.cmp_b = st_nxt.cmp_b_buf;
		end

		// Sticky flags, write one to clear, a new event wins
		flag_set[FLAG_OVF]     = ovf_set;
		flag_set[FLAG_MATCH_A] = match_a;
		flag_set[FLAG_MATCH_B] = match_b;
		st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;

		// Read data for the following cycle only
		st_nxt.rdata = 8'h00;
		if (i_rd)
		begin
			unique case (i_addr)
				ADDR_CTRL_A: st_nxt.rdata = st_r.ctrl_a & CTRL_A_WMASK;
				ADDR_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
				ADDR_COUNT:  st_nxt.rdata = st_r.count;
				ADDR_CMP_A:  st_nxt.rdata = st_r.cmp_a_buf;
				ADDR_CMP_B:  st_nxt.rdata = st_r.cmp_b_buf;
				ADDR_FLAGS:  st_nxt.rdata = {5'h00, st_r.flags};
				default:     st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// State register, frozen by clock enable
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			st_r <= '0;
		else if (i_clk_en)
			st_r <= st_nxt;
	end

	assign o_rdata         = st_r.rdata;
	assign o_overflow_flag = st_r.flags[FLAG_OVF];

	////////////////////////////////////////////////////////////////////////////
	// Compare output channels
	wave_channel #(
		.PWM_TOGGLE (1'b1)
	) u_chan_a (
		.i_clk_sys            (i_clk_sys),
		.i_sys_rst            (i_sys_rst),
		.i_clk_en             (i_clk_en),
		.i_out_mode           (chan_a_mode),
		.i_wave_class         (wave_class),
		.i_wave_mode_high_bit (st_r.ctrl_b[WAVE_HIGH_POS]),
		.i_match              (match_a),
		.i_wrap_top           (wrap_top),
		.i_count_up           (st_r.count_up),
		.i_cmp_is_top         (st_r.cmp_a == top),
		.o_wave_out           (o_chan_a_wave_out),
		.o_pin_override       (o_chan_a_pin_override)
	);

	// Channel B has no PWM toggle mode
	wave_channel #(
		.PWM_TOGGLE (1'b0)
	) u_chan_b (
		.i_clk_sys            (i_clk_sys),
		.i_sys_rst            (i_sys_rst),
		.i_clk_en             (i_clk_en),
		.i_out_mode           (chan_b_mode),
		.i_wave_class         (wave_class),
		.i_wave_mode_high_bit (st_r.ctrl_b[WAVE_HIGH_POS]),
		.i_match              (match_b),
		.i_wrap_top           (wrap_top),
		.i_count_up           (st_r.count_up),
		.i_cmp_is_top         (st_r.cmp_b == top),
		.o_wave_out           (o_chan_b_wave_out),
		.o_pin_override       (o_chan_b_pin_override)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence run_tick_s;
		i_clk_en && tick && !wr_count;
	endsequence

	sequence cmp_a_write_s;
		i_clk_en && i_wr && i_addr == ADDR_CMP_A;
	endsequence

	ctrl_resv_a: assert property (i_clk_en && i_rd && i_addr == ADDR_CTRL_A
		|=> o_rdata[3:2] == 2'b00)
		else $error("reserved control bits read nonzero");
	normal_wrap_a: assert property (run_tick_s ##0 wave_mode == WAVE_NORMAL
		&& st_r.count == COUNT_MAX |=> st_r.count == COUNT_BOTTOM && o_overflow_flag)
		else $error("normal mode wrap or overflow wrong");
	ctc_top_a: assert property (run_tick_s ##0 wave_mode == WAVE_CTC
		&& st_r.count == st_r.cmp_a |=> st_r.count == COUNT_BOTTOM)
		else $error("clear on match did not clear counter");
	pc_turn_a: assert property (run_tick_s ##0 wave_class == CLS_PHASE
		&& st_r.count_up && at_top |=> !st_r.count_up)
		else $error("phase correct did not turn at top");
	pc_ovf_a: assert property (run_tick_s ##0 wave_class == CLS_PHASE
		&& !st_r.count_up && st_r.count == COUNT_BOTTOM |=> o_overflow_flag ##0 st_r.count_up)
		else $error("phase correct overflow at bottom missing");
	fast_top_ovf_a: assert property (run_tick_s ##0 wave_mode == WAVE_FAST_CMP
		&& at_top |=> o_overflow_flag && st_r.count == COUNT_BOTTOM)
		else $error("fast pwm overflow at top missing");
	imm_update_a: assert property (cmp_a_write_s ##0 wave_class == CLS_NONPWM
		|=> st_r.cmp_a == $past(i_wdata))
		else $error("compare not updated immediately");
	buffered_a: assert property (cmp_a_write_s ##0 wave_class == CLS_FAST
		&& !top_update |=> st_r.cmp_a == $past(st_r.cmp_a))
		else $error("buffered compare changed before top");

endmodule

// ---- bench/pin_model.sv ----
// Behavioural model of a compare output pin with its direction bit
module pin_model
(
	input  wire logic i_clk_sys,
	input  wire logic i_dir_out,
	input  wire logic i_override,
	input  wire logic i_wave,
	input  wire logic i_port_val,
	output logic      o_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	logic last_r;

	////////////////////////////////////////////////////////////////////////////
	// Driver on only as output; an undriven pad shows the inverse of its last level
	assign o_pin = i_dir_out ? (i_override ? i_wave : i_port_val) : ~last_r;

	// Remember the last driven level
	always_ff @(posedge i_clk_sys)
	begin
		if (i_dir_out)
		begin
			last_r <= o_pin;
		end
	end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the timer waveform block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_wave_pkg::*;

	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic       clk_en  = 1'b1;
	logic [2:0] addr    = 3'h0;
	logic [7:0] wdata   = 8'h00;
	logic       wr      = 1'b0;
	logic       rd      = 1'b0;
	logic [7:0] rdata;
	logic       a_wave;
	logic       a_ovr;
	logic       b_wave;
	logic       b_ovr;
	logic       ovf_flag;
	logic       dir_out  = 1'b1;
	logic       port_val = 1'b0;
	logic       pin_a;
	int         mismatches = 0;
	int         checks     = 0;

	timer_wave_ctrl u_dut (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_clk_en(clk_en),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_chan_a_wave_out(a_wave), .o_chan_a_pin_override(a_ovr),
		.o_chan_b_wave_out(b_wave), .o_chan_b_pin_override(b_ovr),
		.o_overflow_flag(ovf_flag));

	pin_model u_pin (.i_clk_sys(clk_sys), .i_dir_out(dir_out), .i_override(a_ovr),
		.i_wave(a_wave), .i_port_val(port_val), .o_pin(pin_a));

	// 250 MHz system clock
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step();
		@(posedge clk_sys);
		#1;
	endtask

	// One-cycle write strobe
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// One-cycle read strobe; data stand in the following cycle only
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	function automatic logic sig(input int ch);
		case (ch)
			0: return a_wave;
			1: return b_wave;
			default: return ovf_flag;
		endcase
	endfunction

	task automatic wait_lvl(input int ch, input logic val, input int lim);
		int n;
		n = 0;
		while (sig(ch) !== val && n < lim)
		begin
			step();
			n++;
		end
		if (sig(ch) !== val)
		begin
			chk("wait for level", {15'h0, sig(ch)}, {15'h0, val});
			stop_test();
		end
	endtask

	// Stop, load compares in normal mode, then select mode and run undivided
	task automatic setup(input logic [7:0] ctrl, input logic hb, input logic [7:0] ca,
		input logic [7:0] cb);
		wr_reg(ADDR_CTRL_B, 8'h00);
		wr_reg(ADDR_CTRL_A, 8'h00);
		wr_reg(ADDR_COUNT, 8'h00);
		wr_reg(ADDR_CMP_A, ca);
		wr_reg(ADDR_CMP_B, cb);
		wr_reg(ADDR_CTRL_A, ctrl);
		wr_reg(ADDR_CTRL_B, {4'h0, hb, 3'h1});
	endtask

	// High width and period of a settled waveform
	task automatic measure(input int ch, input int hi_exp, input int per_exp);
		int hi;
		int per;
		hi = 0;
		wait_lvl(ch, 1'b0, 1200);
		wait_lvl(ch, 1'b1, 1200);
		wait_lvl(ch, 1'b0, 1200);
		wait_lvl(ch, 1'b1, 1200);
		while (sig(ch) === 1'b1 && hi < 1200)
		begin
			step();
			hi++;
		end
		per = hi;
		while (sig(ch) === 1'b0 && per < 1200)
		begin
			step();
			per++;
		end
		chk("high width", hi[15:0], hi_exp[15:0]);
		chk("period", per[15:0], per_exp[15:0]);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		logic [7:0] d;
		rd_reg(ADDR_CTRL_A, d);
		chk("ctrl a reset", {8'h0, d}, {8'h0, CTRL_A_RESET});
		chk("override reset", {14'h0, a_ovr, b_ovr}, 16'h0000);
		wr_reg(ADDR_CTRL_A, 8'hff);
		rd_reg(ADDR_CTRL_A, d);
		chk("ctrl a masked", {8'h0, d}, 16'h00f3);
		chk("overrides on", {14'h0, a_ovr, b_ovr}, 16'h0003);
		rd_reg(3'h6, d);
		chk("unmapped read", {8'h0, d}, 16'h0000);
		wr_reg(ADDR_CTRL_A, 8'ha0);
		wr_reg(ADDR_CTRL_B, 8'h08);
		step();
		chk("reserved mode 4", {14'h0, a_ovr, b_ovr}, 16'h0000);
		wr_reg(ADDR_CTRL_A, 8'h00);
		wr_reg(ADDR_CTRL_B, 8'h00);
		step();
		chk("overrides off", {14'h0, a_ovr, b_ovr}, 16'h0000);
	endtask

	task automatic t_nonpwm();
		setup(8'h50, 1'b0, 8'h10, 8'h10);
		measure(0, 256, 512);
		setup(8'h52, 1'b0, 8'h20, 8'h05);
		measure(1, 33, 66);
		measure(0, 33, 66);
		wr_reg(ADDR_FLAGS, 8'h01);
		repeat (300) step();
		chk("no overflow below max", {15'h0, ovf_flag}, 16'h0000);
		setup(8'hf0, 1'b0, 8'h10, 8'h20);
		wait_lvl(0, 1'b1, 300);
		wait_lvl(1, 1'b1, 300);
		chk("set on match", {14'h0, a_wave, b_wave}, 16'h0003);
		wr_reg(ADDR_CTRL_A, 8'ha0);
		wait_lvl(0, 1'b0, 300);
		wait_lvl(1, 1'b0, 300);
		chk("clear on match", {14'h0, a_wave, b_wave}, 16'h0000);
	endtask

	task automatic t_fast();
		setup(8'hb3, 1'b0, 8'h05, 8'h05);
		measure(0, 6, 256);
		measure(1, 250, 256);
		setup(8'h63, 1'b1, 8'h20, 8'h08);
		step();
		chk("toggle override", {15'h0, a_ovr}, 16'h0001);
		measure(0, 33, 66);
		measure(1, 9, 33);
		wr_reg(ADDR_FLAGS, 8'h01);
		step();
		wait_lvl(2, 1'b1, 40);
		chk("overflow at top", {15'h0, ovf_flag}, 16'h0001);
		setup(8'h53, 1'b0, 8'h20, 8'h08);
		step();
		chk("pwm 01 no override", {14'h0, a_ovr, b_ovr}, 16'h0000);
	endtask

	task automatic t_phase();
		setup(8'hb1, 1'b0, 8'h40, 8'h40);
		measure(0, 128, 510);
		measure(1, 382, 510);
		wr_reg(ADDR_FLAGS, 8'h01);
		step();
		wait_lvl(2, 1'b1, 520);
		chk("overflow at bottom", {15'h0, ovf_flag}, 16'h0001);
		setup(8'h21, 1'b1, 8'h40, 8'h10);
		step();
		chk("a disconnected", {15'h0, a_ovr}, 16'h0000);
		measure(1, 32, 128);
	endtask

	task automatic t_top();
		int bad;
		bad = 0;
		setup(8'hb3, 1'b0, 8'hff, 8'hff);
		wait_lvl(0, 1'b1, 300);
		wait_lvl(1, 1'b0, 300);
		repeat (600)
		begin
			step();
			if (a_wave !== 1'b1 || b_wave !== 1'b0)
				bad++;
		end
		chk("compare at top", bad[15:0], 16'h0000);
	endtask

	task automatic t_pin();
		int bad;
		logic lvl;
		bad = 0;
		setup(8'h83, 1'b0, 8'h05, 8'h05);
		repeat (300)
		begin
			step();
			if (pin_a !== a_wave)
				bad++;
		end
		chk("pin follows wave", bad[15:0], 16'h0000);
		// Clock enable low must freeze a running waveform for a whole period
		clk_en <= 1'b0;
		step();
		lvl = a_wave;
		bad = 0;
		repeat (300)
		begin
			step();
			if (a_wave !== lvl)
				bad++;
		end
		clk_en <= 1'b1;
		chk("frozen by enable", bad[15:0], 16'h0000);
		port_val <= 1'b1;
		wr_reg(ADDR_CTRL_A, 8'h03);
		step();
		chk("pin back to port", {15'h0, pin_a}, 16'h0001);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_regs();
		t_nonpwm();
		t_fast();
		t_phase();
		t_top();
		t_pin();
		stop_test();
	end
endmodule
